// >>> hdl/rcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_top import rcc_pkg::*; #(
    parameter int unsigned CLK_HZ = CLK_RATE_HZ
) (
    input  wire logic         CLK_I,
    input  wire logic         RST_N_I,
    input  wire logic         POR_N_I,
    input  wire logic         RXD_I,
    output var  logic         TXD_O,
    output var  logic [1:0]   TX_POWER_CODE_O,
    output var  logic [2:0]   ADDR_SCHEME_O,
    output var  logic         LONG_PREAMBLE_O,
    output var  logic         ACK_REQUEST_O,
    output var  logic         ENCRYPT_O,
    output var  logic [7:0]   UART_RATE_CODE_O
);

    // ==========================================================
    // types and helpers
    typedef enum logic [6:0] {
        ST_HDR   = 7'b000_0001,
        ST_SIZE  = 7'b000_0010,
        ST_FIRST = 7'b000_0100,
        ST_RADDR = 7'b000_1000,
        ST_WVAL  = 7'b001_0000,
        ST_SEND  = 7'b010_0000,
        ST_DRAIN = 7'b100_0000
    } rcc_state_t;

    // one-hot select: [2:0] live power/rate/flags, [5:3] saved
    function automatic logic [5:0] addr_sel(input logic [7:0] a);
        logic [5:0] s;
        s = 6'h00;
        s[0] = (a == VADDR_POWER);
        s[3] = (a == SADDR_POWER);
        s[1] = (a == VADDR_RATE);
        s[4] = (a == SADDR_RATE);
        s[2] = (a == VADDR_FLAGS);
        s[5] = (a == SADDR_FLAGS);
        return s;
    endfunction

    // cycles per serial bit for a rate code
    function automatic logic [DIV_W-1:0] rate_div(
        input logic [7:0] code
    );
        logic [2:0] idx;
        idx = 3'h0;
        if ((code != 8'h00) && (code <= 8'h07)) idx = code[2:0];
        return DIV_W'(CLK_HZ / BAUD_BPS[idx]);
    endfunction

    // ==========================================================
    // state
    rcc_state_t     st_q, st_d;
    rcc_cfg_t       vol_q, vol_d;
    rcc_cfg_t       sav_q, sav_d;
    logic [7:0]     rate_q, rate_d;
    logic [7:0]     addr_q, addr_d;
    logic [7:0]     val_q, val_d;
    logic [1:0]     sent_q, sent_d;
    logic [1:0]     last_q, last_d;
    logic           txv_q, txv_d;
    logic [7:0]     txb_q, txb_d;
    logic           pend_q, pend_d;

    wire            sys_rst_n = RST_N_I & POR_N_I;
    wire            rx_valid;
    wire [7:0]      rx_data;
    wire            tx_ready;
    wire [DIV_W-1:0] div;

    // the serial rate follows the applied code, not the live byte
    assign div = rate_div(rate_q);

    // ==========================================================
    // serial ends
    rcc_uart_rx #(
        .W       (DIV_W)
    ) u_rx (
        .clk_i   (CLK_I),
        .rst_n_i (sys_rst_n),
        .div_i   (div),
        .rxd_i   (RXD_I),
        .valid_o (rx_valid),
        .data_o  (rx_data)
    );

    rcc_uart_tx #(
        .W       (DIV_W)
    ) u_tx (
        .clk_i   (CLK_I),
        .rst_n_i (sys_rst_n),
        .div_i   (div),
        .valid_i (txv_q),
        .data_i  (txb_q),
        .ready_o (tx_ready),
        .txd_o   (TXD_O)
    );

    // ==========================================================
    // decode of read and write addresses
    wire [5:0]      rd_sel  = addr_sel(rx_data);
    wire            rd_hit  = |rd_sel;
    wire            wr_en   = (st_q == ST_WVAL) & rx_valid;
    wire [5:0]      wr_sel  = addr_sel(addr_q) & {6{wr_en}};
    wire            wr_hit  = |addr_sel(addr_q);
    wire [47:0]     cfg_all = {sav_q, vol_q};
    wire [7:0]      rd_val;

    assign rd_val = ({8{rd_sel[0]}} & vol_q.power)
                  | ({8{rd_sel[1]}} & vol_q.rate)
                  | ({8{rd_sel[2]}} & vol_q.flags)
                  | ({8{rd_sel[3]}} & sav_q.power)
                  | ({8{rd_sel[4]}} & sav_q.rate)
                  | ({8{rd_sel[5]}} & sav_q.flags);

    // byte writes: each copy takes only its own address
    for (genvar i = 0; i < 3; i++) begin : g_wr
        assign vol_d[8*i +: 8] = wr_sel[i]   ? rx_data
                                             : cfg_all[8*i +: 8];
        assign sav_d[8*i +: 8] = wr_sel[i+3] ? rx_data
                                             : cfg_all[24+8*i +: 8];
    end

    // reply bytes in order: ack, echoed address, value
    wire [7:0] reply_byte = (sent_q == 2'd0) ? ACK_BYTE
                          : (sent_q == 2'd1) ? addr_q : val_q;

    // ==========================================================
    // command parser and responder
    always_comb begin
        st_d   = st_q;
        addr_d = addr_q;
        val_d  = val_q;
        sent_d = sent_q;
        last_d = last_q;
        txv_d  = txv_q;
        txb_d  = txb_q;
        pend_d = pend_q;
        rate_d = rate_q;
        case (st_q)
            ST_HDR: begin
                if (rx_valid && (rx_data == HDR_BYTE)) st_d = ST_SIZE;
            end
            ST_SIZE: begin
                // a repeated header keeps the parser in sync
                if (rx_valid) begin
                    if (rx_data == SIZE_BYTE)     st_d = ST_FIRST;
                    else if (rx_data != HDR_BYTE) st_d = ST_HDR;
                end
            end
            ST_FIRST: begin
                // no escape means a write address
                if (rx_valid) begin
                    if (rx_data == ESC_BYTE) begin
                        st_d = ST_RADDR;
                    end else begin
                        addr_d = rx_data;
                        st_d   = ST_WVAL;
                    end
                end
            end
            ST_RADDR: begin
                // latch echo and value, three byte reply
                if (rx_valid) begin
                    addr_d = rx_data;
                    val_d  = rd_val;
                    sent_d = 2'd0;
                    last_d = 2'd2;
                    st_d   = rd_hit ? ST_SEND : ST_HDR;
                end
            end
            ST_WVAL: begin
                // a write is acknowledged with the ack byte alone
                if (rx_valid) begin
                    sent_d = 2'd0;
                    last_d = 2'd0;
                    pend_d = wr_sel[1];
                    st_d   = wr_hit ? ST_SEND : ST_HDR;
                end
            end
            ST_SEND: begin
                if (!txv_q) begin
                    txv_d = 1'b1;
                    txb_d = reply_byte;
                end else if (tx_ready) begin
                    txv_d = 1'b0;
                    if (sent_q == last_q) st_d   = ST_DRAIN;
                    else                  sent_d = sent_q + 2'd1;
                end
            end
            ST_DRAIN: begin
                // new rate only once the ack has left
                if (tx_ready) begin
                    if (pend_q) rate_d = vol_q.rate;
                    pend_d = 1'b0;
                    st_d   = ST_HDR;
                end
            end
            default: st_d = ST_HDR;
        endcase
    end

    // ==========================================================
    // configuration bytes; saved copies survive a plain reset
    always_ff @(posedge CLK_I) begin
        if (!POR_N_I) begin
            vol_q  <= CFG_RST;
            sav_q  <= CFG_RST;
            rate_q <= RATE_RST;
        end else if (!RST_N_I) begin
            // live bytes reload from saved bytes
            vol_q  <= sav_q;
            // saved rate takes effect here only
            rate_q <= sav_q.rate;
        end else begin
            vol_q  <= vol_d;
            sav_q  <= sav_d;
            rate_q <= rate_d;
        end
    end

    // ==========================================================
    // parser registers
    always_ff @(posedge CLK_I) begin
        if (!sys_rst_n) begin
            st_q   <= ST_HDR;
            addr_q <= 8'h00;
            val_q  <= 8'h00;
            sent_q <= 2'd0;
            last_q <= 2'd0;
            txv_q  <= 1'b0;
            txb_q  <= 8'h00;
            pend_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            addr_q <= addr_d;
            val_q  <= val_d;
            sent_q <= sent_d;
            last_q <= last_d;
            txv_q  <= txv_d;
            txb_q  <= txb_d;
            pend_q <= pend_d;
        end
    end

    // ==========================================================
    // radio settings straight from the live bytes; the serial rate code comes from the applied rate
    // two-bit power code drives output level
    assign TX_POWER_CODE_O  = vol_q.power[POWER_W-1:0];
    // scheme passed through; reserved codes unchecked
    assign ADDR_SCHEME_O    = vol_q.flags[SCHEME_LSB +: SCHEME_W];
    assign LONG_PREAMBLE_O  = vol_q.flags[PREAMBLE_BIT];
    assign ACK_REQUEST_O    = vol_q.flags[ACKREQ_BIT];
    assign ENCRYPT_O        = vol_q.flags[ENCRYPT_BIT];
    assign UART_RATE_CODE_O = rate_q;

endmodule // rcc_top
`default_nettype wire

// >>> hdl/rcc_pkg.sv
package rcc_pkg;

    // ==========================================================
    // clock and serial timing
    localparam int unsigned CLK_RATE_HZ = 200_000_000;
    localparam int unsigned DIV_W       = 16;
    // index 0 stands for every unsupported code
    localparam int unsigned BAUD_BPS [8] = '{
        9600, 9600, 19200, 38400, 57600, 115200, 10400, 31250};
    localparam int unsigned RF_RATE_BPS = 38384;

    // ==========================================================
    // command framing bytes
    localparam logic [7:0] HDR_BYTE  = 8'hFF;
    localparam logic [7:0] SIZE_BYTE = 8'h02;
    localparam logic [7:0] ESC_BYTE  = 8'hFE;
    localparam logic [7:0] ACK_BYTE  = 8'h06;

    // ==========================================================
    // configuration addresses
    localparam logic [7:0] VADDR_POWER = 8'h4D;
    localparam logic [7:0] VADDR_RATE  = 8'h4E;
    localparam logic [7:0] VADDR_FLAGS = 8'h4F;
    localparam logic [7:0] SADDR_POWER = 8'h02;
    localparam logic [7:0] SADDR_RATE  = 8'h03;
    localparam logic [7:0] SADDR_FLAGS = 8'h04;

    // ==========================================================
    // reset values
    localparam logic [7:0] POWER_RST = 8'h03;
    localparam logic [7:0] RATE_RST  = 8'h01;
    localparam logic [7:0] FLAGS_RST = 8'h04;

    // ==========================================================
    // field layout
    localparam int unsigned POWER_W      = 2;
    localparam int unsigned SCHEME_LSB   = 0;
    localparam int unsigned SCHEME_W     = 3;
    localparam int unsigned PREAMBLE_BIT = 3;
    localparam int unsigned ACKREQ_BIT   = 4;
    localparam int unsigned ENCRYPT_BIT  = 5;
    localparam logic [2:0] SCHEME_SERIAL = 3'h4;
    localparam logic [2:0] SCHEME_USER   = 3'h6;
    localparam logic [2:0] SCHEME_EXT    = 3'h7;
    localparam logic [1:0] POWER_M5DBM   = 2'h0;
    localparam logic [1:0] POWER_0DBM    = 2'h1;
    localparam logic [1:0] POWER_P5DBM   = 2'h2;
    localparam logic [1:0] POWER_P9DBM   = 2'h3;

    // ==========================================================
    // carrier for the three configuration bytes
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] rate;
        logic [7:0] power;
    } rcc_cfg_t;

    localparam rcc_cfg_t CFG_RST = '{
        flags: FLAGS_RST, rate: RATE_RST, power: POWER_RST};

endpackage

// >>> hdl/rcc_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_uart_rx import rcc_pkg::*; #(
    parameter int unsigned W = DIV_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] div_i,
    input  wire logic         rxd_i,
    output var  logic         valid_o,
    output var  logic [7:0]   data_o
);

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rcc_rx_t;

    rcc_rx_t        st_q, st_d;
    logic [W-1:0]   cnt_q, cnt_d;
    logic [2:0]     bit_q, bit_d;
    logic [7:0]     sh_q, sh_d;
    logic           vld_d;
    logic [7:0]     dat_d;
    wire            tick = (cnt_q == '0);

    // ==========================================================
    // frame sampling; start bit checked at half a bit to reject
    // glitches, data and stop bits at mid-bit
    always_comb begin
        st_d  = st_q;
        cnt_d = tick ? cnt_q : cnt_q - 1'b1;
        bit_d = bit_q;
        sh_d  = sh_q;
        vld_d = 1'b0;
        dat_d = data_o;
        case (st_q)
            RX_IDLE: begin
                if (!rxd_i) begin
                    st_d  = RX_START;
                    cnt_d = div_i >> 1;
                end
            end
            RX_START: begin
                if (tick) begin
                    st_d  = rxd_i ? RX_IDLE : RX_DATA;
                    cnt_d = div_i - 1'b1;
                    bit_d = 3'h0;
                end
            end
            RX_DATA: begin
                if (tick) begin
                    sh_d  = {rxd_i, sh_q[7:1]};
                    cnt_d = div_i - 1'b1;
                    bit_d = bit_q + 1'b1;
                    if (bit_q == 3'h7) st_d = RX_STOP;
                end
            end
            RX_STOP: begin
                if (tick) begin
                    // a missing stop bit drops the byte
                    vld_d = rxd_i;
                    dat_d = rxd_i ? sh_q : data_o;
                    st_d  = RX_IDLE;
                end
            end
            default: st_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q    <= RX_IDLE;
            cnt_q   <= '0;
            bit_q   <= 3'h0;
            sh_q    <= 8'h00;
            valid_o <= 1'b0;
            data_o  <= 8'h00;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            valid_o <= vld_d;
            data_o  <= dat_d;
        end
    end

endmodule // rcc_uart_rx
`default_nettype wire

// >>> hdl/rcc_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_uart_tx import rcc_pkg::*; #(
    parameter int unsigned W = DIV_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] div_i,
    input  wire logic         valid_i,
    input  wire logic [7:0]   data_i,
    output var  logic         ready_o,
    output var  logic         txd_o
);

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } rcc_tx_t;

    rcc_tx_t        st_q;
    logic [W-1:0]   cnt_q;
    logic [3:0]     n_q;
    logic [9:0]     fr_q;
    wire            tick  = (cnt_q == '0);
    wire            take  = (st_q == TX_IDLE) & valid_i;
    wire            last  = tick & (n_q == 4'h9);

    // ready only while idle, so the stop bit is never cut short
    assign ready_o = (st_q == TX_IDLE);

    // ==========================================================
    // state and bit timer
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q  <= TX_IDLE;
            cnt_q <= '0;
        end else begin
            case (st_q)
                TX_IDLE:  st_q <= take ? TX_SHIFT : TX_IDLE;
                TX_SHIFT: st_q <= last ? TX_IDLE : TX_SHIFT;
                default:  st_q <= TX_IDLE;
            endcase
            cnt_q <= (take | tick) ? div_i - 1'b1 : cnt_q - 1'b1;
        end
    end

    // ==========================================================
    // frame shifter: start, eight data bits lsb first, stop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            n_q   <= 4'h0;
            fr_q  <= 10'h3FF;
            txd_o <= 1'b1;
        end else if (take) begin
            n_q   <= 4'h0;
            fr_q  <= {1'b1, data_i, 1'b0};
            txd_o <= 1'b0;
        end else if ((st_q == TX_SHIFT) & tick & !last) begin
            n_q   <= n_q + 1'b1;
            fr_q  <= {1'b1, fr_q[9:1]};
            txd_o <= fr_q[1];
        end
    end

endmodule // rcc_uart_tx
`default_nettype wire

// >>> sim/rcc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the command register block
module rcc_top_checker import rcc_pkg::*; #(
    parameter int unsigned CLK_HZ = CLK_RATE_HZ
) (
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic       POR_N_I,
    input wire logic       RXD_I,
    input wire logic       TXD_O,
    input wire logic [1:0] TX_POWER_CODE_O,
    input wire logic [2:0] ADDR_SCHEME_O,
    input wire logic       LONG_PREAMBLE_O,
    input wire logic       ACK_REQUEST_O,
    input wire logic       ENCRYPT_O,
    input wire logic [7:0] UART_RATE_CODE_O
);
    localparam int DIV_MIN = CLK_HZ / 115200;
    localparam int LOW_MAX = 9 * (CLK_HZ / 9600) + 2;
    logic [15:0] hi_cnt_q;
    logic [15:0] lo_cnt_q;
    wire logic       run = RST_N_I && POR_N_I;
    wire logic [7:0] cfg = {ENCRYPT_O, ACK_REQUEST_O, LONG_PREAMBLE_O,
                            ADDR_SCHEME_O, TX_POWER_CODE_O};

    // run lengths of the serial line; high count saturates, never wraps
    always_ff @(posedge CLK_I) begin
        if (!run) begin
            hi_cnt_q <= 16'h0000;
            lo_cnt_q <= 16'h0000;
        end else begin
            hi_cnt_q <= !TXD_O ? 16'h0000 : hi_cnt_q + {15'h0000, ~&hi_cnt_q};
            lo_cnt_q <= TXD_O ? 16'h0000 : lo_cnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!run);

    // start bit stays low for at least nine clocks at the fastest rate
    sequence start_s;
        $fell(TXD_O) ##1 !TXD_O [*8];
    endsequence
    // a config output moved outside any reset
    sequence cfg_step_s;
        $changed(cfg) && $past(run);
    endsequence

    // power 3, scheme 4, no flags, rate code 1
    chk_por_defaults: assert property (disable iff (!RST_N_I)
        !POR_N_I |=> cfg == 8'h13 && UART_RATE_CODE_O == 8'h01)
        else $error("outputs not at defaults after power-up reset");
    chk_reset_txd_idle: assert property (disable iff (!POR_N_I)
        !RST_N_I |=> TXD_O)
        else $error("serial output not idle during reset");
    chk_start_bit_len: assert property ($fell(TXD_O) |-> start_s)
        else $error("start bit too short");
    chk_low_run_max: assert property (lo_cnt_q <= LOW_MAX)
        else $error("serial output low longer than one frame");
    chk_rate_after_ack: assert property (
        $changed(UART_RATE_CODE_O) && $past(run) |-> hi_cnt_q >= DIV_MIN)
        else $error("rate switched before the stop bit ended");
    chk_rate_quiet_txd: assert property (
        !TXD_O && $past(run) |-> $stable(UART_RATE_CODE_O))
        else $error("rate switched in mid frame");
    chk_cfg_after_stop: assert property (
        cfg_step_s |-> $past(RXD_I) && $past(RXD_I, 2))
        else $error("config changed away from a received stop bit");
    chk_cfg_steady_tx: assert property (cfg_step_s |-> TXD_O)
        else $error("config changed while replying");
endmodule // rcc_top_checker

bind rcc_top rcc_top_checker #(.CLK_HZ(CLK_HZ)) chk_u (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .POR_N_I(POR_N_I),
    .RXD_I(RXD_I), .TXD_O(TXD_O), .TX_POWER_CODE_O(TX_POWER_CODE_O),
    .ADDR_SCHEME_O(ADDR_SCHEME_O), .LONG_PREAMBLE_O(LONG_PREAMBLE_O),
    .ACK_REQUEST_O(ACK_REQUEST_O), .ENCRYPT_O(ENCRYPT_O),
    .UART_RATE_CODE_O(UART_RATE_CODE_O));
`default_nettype wire

// >>> sim/rcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side of the serial command link
module rcc_host_model import rcc_pkg::*; (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output var  logic rxd_o
);
    // line rests high between frames
    initial rxd_o = 1'b1;

    // one 8N1 frame, lsb first; entered just after a rising edge
    task automatic send_byte(input logic [7:0] b, input int div);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= fr[i];
            repeat (div) @(posedge clk_i);
        end
    endtask

    // bounded wait for a start bit, then mid-bit sampling
    task automatic get_byte(input int div, input int quiet,
                            output logic [7:0] b, output bit ok);
        int n;
        b = 8'h00;
        ok = 1'b0;
        n = 0;
        while (txd_i === 1'b1 && n < quiet) begin
            @(posedge clk_i);
            n++;
        end
        if (txd_i !== 1'b0) return;
        repeat (div / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (div) @(posedge clk_i);
        ok = (txd_i === 1'b1);
    endtask

    // whole command; listening starts while the last byte goes out
    task automatic xfer(input logic [7:0] a, input logic [7:0] v,
                        input bit rd, input logic [7:0] sz, input int div,
                        output logic [7:0] r [3], output int got);
        logic [7:0] fr [4];
        bit ok;
        if (rd) fr = '{HDR_BYTE, sz, ESC_BYTE, a};
        else fr = '{HDR_BYTE, sz, a, v};
        got = 0;
        r = '{8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 3; i++) send_byte(fr[i], div);
        fork
            send_byte(fr[3], div);
            begin
                repeat (9 * div) @(posedge clk_i);
                ok = 1'b1;
                while (ok && got < 3) begin
                    get_byte(div, (got == 0) ? 6 * div : 3 * div, r[got], ok);
                    if (ok) got++;
                end
            end
        join
    endtask
endmodule // rcc_host_model
`default_nettype wire

// >>> sim/radio_config_command_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// command register bench
module radio_config_command_regs_bench
    import rcc_pkg::*;
;
    localparam int unsigned SIM_HZ = 1_152_000;
    localparam int          D_SLOW = SIM_HZ / 9600;
    typedef struct packed {logic [7:0] addr; logic [7:0] val;} rcc_row_t;
    // rate codes first then power, flags and saved copies
    rcc_row_t rows [20] = '{16'h4E02, 16'h4E06, 16'h4E07, 16'h4E03,
        16'h4E04, 16'h4E05, 16'h4D00, 16'h4D01, 16'h4D02, 16'h4D03,
        16'h4F04, 16'h4F06, 16'h4F07, 16'h4F0C, 16'h4F14, 16'h4F24,
        16'h4F3F, 16'h0201, 16'h0305, 16'h042E};
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic       por_n = 1'b0;
    logic       rxd, txd, pre, ackr, enc;
    logic [1:0] power_code;
    logic [2:0] scheme;
    logic [7:0] rate, rate_ap;
    logic [7:0] sv [3];
    logic [7:0] lv [3];
    logic [7:0] r [3];
    int         err_total = 0;
    int         checks_done = 0;
    int         div = D_SLOW;
    int         got;

    always #2.5 clk = ~clk;

    rcc_top #(.CLK_HZ(SIM_HZ)) dut_u (.CLK_I(clk), .RST_N_I(rst_n),
        .POR_N_I(por_n), .RXD_I(rxd), .TXD_O(txd), .TX_POWER_CODE_O(power_code),
        .ADDR_SCHEME_O(scheme), .LONG_PREAMBLE_O(pre), .ACK_REQUEST_O(ackr),
        .ENCRYPT_O(enc), .UART_RATE_CODE_O(rate));
    rcc_host_model host_u (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // shadow slot: 0 power, 1 rate, 2 flags
    function automatic int slot(input logic [7:0] a);
        if (a == VADDR_POWER || a == SADDR_POWER) return 0;
        if (a == VADDR_RATE || a == SADDR_RATE) return 1;
        return 2;
    endfunction

    // unsupported codes run at the default rate
    function automatic int div_of(input logic [7:0] c);
        return (c >= 8'h01 && c <= 8'h07) ? SIM_HZ / BAUD_BPS[c[2:0]] : D_SLOW;
    endfunction

    task automatic outs();
        chk("power code", {6'h00, power_code}, {6'h00, lv[0][1:0]});
        chk("flags", {2'h0, enc, ackr, pre, scheme}, lv[2] & 8'h3F);
        chk("applied rate", rate, rate_ap);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host_u.xfer(a, v, 1'b0, SIZE_BYTE, div, r, got);
        chk("write reply count", 8'(got), 8'h01);
        chk("write ack", r[0], ACK_BYTE);
        if (a >= 8'h40) begin
            lv[slot(a)] = v;
            if (slot(a) == 1) begin
                rate_ap = v;
                div = div_of(v);
            end
        end else begin
            sv[slot(a)] = v;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h40) ? lv[slot(a)] : sv[slot(a)];
        host_u.xfer(a, 8'h00, 1'b1, SIZE_BYTE, div, r, got);
        chk("read reply count", 8'(got), 8'h03);
        chk("read ack", r[0], ACK_BYTE);
        chk("echoed address", r[1], a);
        chk("read value", r[2], e);
    endtask

    task automatic pulse(input bit por);
        @(posedge clk);
        if (por) por_n <= 1'b0;
        else rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // hang guard: running out counts as a mismatch
    initial begin
        repeat (100_000) @(posedge clk);
        err_total++;
        $display("unexpected run length: expected end, seen none");
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        sv = '{8'h03, 8'h01, FLAGS_RST};
        lv = sv;
        rate_ap = 8'h01;
        @(posedge clk);
        outs();
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].val);
            if (rows[i].addr != VADDR_RATE) rd(rows[i].addr);
            outs();
        end
        // unmapped address and bad size byte: silence, no change
        host_u.xfer(8'h50, 8'h00, 1'b1, SIZE_BYTE, div, r, got);
        chk("unmapped reply count", 8'(got), 8'h00);
        host_u.xfer(8'h4D, 8'h00, 1'b0, 8'h03, div, r, got);
        chk("bad size reply count", 8'(got), 8'h00);
        outs();
        // warm reset reloads live bytes and rate from saved copies
        pulse(1'b0);
        lv = sv;
        rate_ap = sv[1];
        div = div_of(sv[1]);
        outs();
        rd(VADDR_FLAGS);
        // unsupported code reads back but runs at the default rate
        wr(VADDR_RATE, 8'h08);
        rd(VADDR_RATE);
        outs();
        // power-up reset restores factory values in both copies
        pulse(1'b1);
        sv = '{8'h03, 8'h01, FLAGS_RST};
        lv = sv;
        rate_ap = 8'h01;
        div = D_SLOW;
        outs();
        rd(SADDR_RATE);
        // warm reset cuts into a reply while the line is low; the line
        // must go idle at once and the next read must answer cleanly
        fork
            host_u.xfer(VADDR_POWER, 8'h00, 1'b1, SIZE_BYTE, div, r, got);
            begin
                repeat (45 * div) @(posedge clk);
                pulse(1'b0);
            end
        join
        chk("line after cut reply", {7'h00, txd}, 8'h01);
        outs();
        rd(VADDR_POWER);
        end_sim();
    end
endmodule // radio_config_command_regs_bench
`default_nettype wire
